// ==== hw/lpc_controller.sv ====
// Purpose: Controller end: issues one command per request
// Assumes: User keeps cmd stable while reqValid and not reqReady
// Notes: Read data returns two cycles after the read is issued
`include "lpc_regs.svh"
`default_nettype none
module lpc_controller #(parameter int DW = 16) (
   input wire logic sysClk,
   input wire logic rst,
   lpc_if.ctl pins,
   input wire logic reqValid,
   output logic reqReady,
   input wire lpc_pkg::lpc_cmd_t reqCmd,
   input wire logic [1:0] reqBank,
   input wire logic [`LPC_ADDR_W-1:0] reqAddr,
   input wire logic [DW-1:0] reqData,
   input wire logic [DW/8-1:0] reqMask,
   input wire logic clkEnableReq,
   output logic rdValid,
   output logic [DW-1:0] rdData,
   output logic hotFlag
);
   import lpc_pkg::*;
   typedef struct packed {
      lpc_cmd_t cmd;
      logic [1:0] bank;
      logic [`LPC_ADDR_W-1:0] addr;
      logic [DW-1:0] wdata;
      logic [DW/8-1:0] mask;
      logic wrOe;
      logic cke;
      lpc_xfer_e xf;
      logic rdV;
      logic [DW-1:0] rd;
      logic hot;
   } lpc_ctl_s;
   lpc_ctl_s st_r, st_nxt;

   assign reqReady = st_r.cke && st_r.xf == LPC_IDLE;

   always_comb begin
      st_nxt = st_r;
      st_nxt.cmd = `LPC_CMD_NOP;
      st_nxt.wrOe = 1'b0;
      st_nxt.rdV = 1'b0;
      st_nxt.hot = pins.tempFlagOut;
      st_nxt.cke = clkEnableReq;
      case (st_r.xf)
         LPC_IDLE: begin
            if (reqValid && reqReady) begin
               st_nxt.cmd = reqCmd;
               st_nxt.bank = reqBank;
               st_nxt.addr = reqAddr;
               st_nxt.wdata = reqData;
               st_nxt.mask = reqMask;
               st_nxt.wrOe = reqCmd == `LPC_CMD_WR;
               if (reqCmd == `LPC_CMD_RD) begin
                  st_nxt.xf = LPC_RDX;
               end
            end
         end
         LPC_RDX: begin
            st_nxt.xf = LPC_WRX;
         end
         default: begin
            if (pins.dqDevOe) begin
               st_nxt.rdV = 1'b1;
               st_nxt.rd = pins.dqDev;
            end
            st_nxt.xf = LPC_IDLE;
         end
      endcase
   end

   always_ff @(posedge sysClk or posedge rst) begin
      if (rst) begin
         st_r <= '{cmd: `LPC_CMD_NOP, xf: LPC_IDLE, default: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pins.clockTrue = 1'b1;
   assign pins.clockComplement = 1'b0;
   assign pins.clkEnable = st_r.cke;
   assign {pins.selectN, pins.rowN, pins.colN, pins.wrN} = st_r.cmd;
   assign {pins.bankSel1, pins.bankSel0} = st_r.bank;
   assign pins.addr = st_r.addr;
   assign pins.writeMask = st_r.mask;
   assign pins.dqCtl = st_r.wdata;
   assign pins.dqCtlOe = st_r.wrOe;
   assign pins.dqsCtl = {(DW/8){st_r.wrOe}};
   assign rdValid = st_r.rdV;
   assign rdData = st_r.rd;
   assign hotFlag = st_r.hot;
endmodule
`default_nettype wire

// ==== hw/lpc_device.sv ====
// Purpose: Device end: command decode, power states, masked store
// Assumes: dq/dqs carry one word per cycle, with no half-cycle split
// Notes: Small array stands for the memory; one beat per command
`include "lpc_regs.svh"
`default_nettype none
module lpc_device #(parameter int DW = 16, parameter int DEPTH = 64) (
   input wire logic sysClk,
   input wire logic rst,
   lpc_if.dev pins,
   input wire logic hotJunction,
   output logic [1:0] pwrState,
   output logic [`LPC_BANKS-1:0] bankOpen,
   output logic [`LPC_ADDR_W-1:0] modeReg0
);
   import lpc_pkg::*;
   localparam int NB = DW/8;
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      lpc_pwr_e pwr;
      logic [`LPC_BANKS-1:0] open;
      logic [`LPC_BANKS-1:0][`LPC_ADDR_W-1:0] mode;
      logic [DW-1:0] rdData;
      logic oe;
      logic [NB-1:0] dqs;
      logic temp;
   } lpc_dev_s;
   lpc_dev_s st_r, st_nxt;
   logic [DW-1:0] mem [DEPTH];
   lpc_cmd_t cmd;
   logic [1:0] bank;
   logic awake, wrHit;
   logic [AW-1:0] colAddr;

   // Close one bank, leave the others as they are
   function automatic logic [`LPC_BANKS-1:0] close_bank(input logic [`LPC_BANKS-1:0] cur, input logic [1:0] b);
      logic [`LPC_BANKS-1:0] res;
      res = cur;
      res[b] = 1'b0;
      return res;
   endfunction

   // ******************
   // Decode
   // ******************
   assign cmd = {pins.selectN, pins.rowN, pins.colN, pins.wrN};
   assign bank = {pins.bankSel1, pins.bankSel0};
   assign colAddr = pins.addr[AW-1:0];
   assign awake = (st_r.pwr == LPC_RUN) && pins.clockTrue && !pins.clockComplement;
   assign wrHit = awake && pins.clkEnable && !pins.selectN && cmd == `LPC_CMD_WR && pins.dqCtlOe;

   always_comb begin
      st_nxt = st_r;
      st_nxt.temp = hotJunction;
      st_nxt.oe = 1'b0;
      st_nxt.dqs = '0;
      case (st_r.pwr)
         LPC_RUN: begin
            if (!pins.clkEnable) begin
               if (st_r.open != '0) begin
                  st_nxt.pwr = LPC_PDN_ACT;
               end else if (!pins.selectN && cmd == `LPC_CMD_REF) begin
                  st_nxt.pwr = LPC_SREF;
               end else begin
                  st_nxt.pwr = LPC_PDN_PRE;
               end
            end else if (awake && !pins.selectN) begin
               if (cmd == `LPC_CMD_ACT) begin
                  st_nxt.open[bank] = 1'b1;
               end else if (cmd == `LPC_CMD_RD) begin
                  // Read word driven in the cycle after the command
                  st_nxt.oe = 1'b1;
                  st_nxt.dqs = {NB{1'b1}};
                  st_nxt.rdData = mem[colAddr];
                  if (pins.addr[`LPC_AP_BIT]) begin
                     st_nxt.open = close_bank(st_nxt.open, bank);
                  end
               end else if (cmd == `LPC_CMD_WR) begin
                  if (pins.addr[`LPC_AP_BIT]) begin
                     st_nxt.open = close_bank(st_nxt.open, bank);
                  end
               end else if (cmd == `LPC_CMD_PRE) begin
                  if (pins.addr[`LPC_AP_BIT]) begin
                     st_nxt.open = '0;
                  end else begin
                     st_nxt.open = close_bank(st_nxt.open, bank);
                  end
               end else if (cmd == `LPC_CMD_MRS) begin
                  st_nxt.mode[bank] = pins.addr;
               end
            end
         end
         LPC_PDN_PRE, LPC_PDN_ACT: begin
            if (pins.clkEnable) begin
               st_nxt.pwr = LPC_RUN;
            end
         end
         default: begin
            st_nxt.pwr = LPC_SREF;
         end
      endcase
   end

   // ******************
   // State
   // ******************
   always_ff @(posedge sysClk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else if (st_r.pwr == LPC_SREF && pins.clkEnable) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Masked byte store, one word per write command
   always_ff @(posedge sysClk) begin
      if (wrHit) begin
         for (int i = 0; i < NB; i++) begin
            if (!pins.writeMask[i]) begin
               mem[colAddr][i*8 +: 8] <= pins.dqCtl[i*8 +: 8];
            end
         end
      end
   end

   assign pins.dqDev = st_r.rdData;
   assign pins.dqDevOe = st_r.oe;
   assign pins.dqsDev = st_r.dqs;
   assign pins.tempFlagOut = st_r.temp;
   assign pwrState = st_r.pwr;
   assign bankOpen = st_r.open;
   assign modeReg0 = st_r.mode[0];
endmodule
`default_nettype wire

// ==== hw/lpc_if.sv ====
// Purpose: Pin set between controller and memory device
// Assumes: One clock; DDR modelled as one word per cycle
// Notes: Two-way pins carry in, out and enable
`default_nettype none
interface lpc_if #(parameter int DW = 16) (input wire logic sysClk);
   logic clockTrue, clockComplement, clkEnable, selectN, rowN, colN, wrN;
   logic bankSel0, bankSel1;
   logic [13:0] addr;
   logic [DW/8-1:0] writeMask;
   logic [DW-1:0] dqCtl, dqDev;
   logic dqCtlOe, dqDevOe;
   logic [DW/8-1:0] dqsCtl, dqsDev;
   logic tempFlagOut;
   // Bus level resolved from the device enable dqDevOe
   wire [DW-1:0] dq = dqDevOe ? dqDev : dqCtl;
   wire [DW/8-1:0] dqs = dqDevOe ? dqsDev : dqsCtl;
   modport dev (input clockTrue, clockComplement, clkEnable, selectN, rowN, colN, wrN,
      bankSel0, bankSel1, addr, writeMask, dqCtl, dqCtlOe, dqsCtl,
      output dqDev, dqDevOe, dqsDev, tempFlagOut);
   modport ctl (output clockTrue, clockComplement, clkEnable, selectN, rowN, colN, wrN,
      bankSel0, bankSel1, addr, writeMask, dqCtl, dqCtlOe, dqsCtl,
      input dqDev, dqDevOe, dqsDev, tempFlagOut);
endinterface
`default_nettype wire

// ==== hw/lpc_pkg.sv ====
// Purpose: Types shared by both ends of the pin interface
// Assumes: Constants live in lpc_regs.svh
// Notes: Power and transfer states are binary coded
`default_nettype none
package lpc_pkg;
   typedef enum logic [1:0] {
      LPC_RUN = 2'b00,
      LPC_PDN_PRE = 2'b01,
      LPC_PDN_ACT = 2'b10,
      LPC_SREF = 2'b11
   } lpc_pwr_e;
   typedef enum logic [1:0] {
      LPC_IDLE = 2'b00,
      LPC_RDX = 2'b01,
      LPC_WRX = 2'b10
   } lpc_xfer_e;
   typedef logic [3:0] lpc_cmd_t;
endpackage
`default_nettype wire

// ==== hw/lpc_regs.svh ====
// Purpose: Constants for the low-power DDR pin command interface
// Assumes: Command codes are {select_n, row_n, col_n, wr_n}
// Notes: Shared by both ends
//
// Summary of operation
// - Controls captured on true clock rising edge
// - Data moves on both clock edges; here one word moves per sysClk rising edge
// - Clock enable high keeps internals running
// - Idle banks: precharge powerdown; else active
// - Clock enable synchronous except self-refresh exit; here that exit is also sampled on the sysClk rising edge
// - Select high masks all command inputs
// - Select plus strobes identify the command
// - Bank selects choose the target bank
// - Bank selects choose mode register loaded
// - Row on activate; column, autoprecharge bit
// - Precharge bit high closes all banks
// - Mode load takes opcode from address
// - Strobes travel with data both ways
// - Read strobe edge-aligned; write strobe centred
// - Data bus sixteen or thirty-two bits
`ifndef LPC_REGS_SVH
`define LPC_REGS_SVH
`define LPC_CMD_NOP 4'h7
`define LPC_CMD_ACT 4'h3
`define LPC_CMD_RD 4'h5
`define LPC_CMD_WR 4'h4
`define LPC_CMD_PRE 4'h2
`define LPC_CMD_REF 4'h1
`define LPC_CMD_MRS 4'h0
`define LPC_CMD_BST 4'h6
`define LPC_AP_BIT 10
`define LPC_ADDR_W 14
`define LPC_BANKS 4
`define LPC_MODE_REGS 4
`endif

// ==== verif/lpc_pins_monitor.sv ====
// Purpose: Pin timing checks between the two ends
// Assumes: Command code is {selectN, rowN, colN, wrN}
// Notes: Watches interface signals only
`default_nettype none
module lpc_pins_monitor (
   input wire logic sysClk,
   input wire logic rst,
   input wire logic clockTrue,
   input wire logic clockComplement,
   input wire logic clkEnable,
   input wire logic selectN,
   input wire logic rowN,
   input wire logic colN,
   input wire logic wrN,
   input wire logic dqCtlOe,
   input wire logic dqDevOe
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // Checks
   // ****
   default clocking cb @(posedge sysClk); endclocking
   default disable iff (rst);
   sequence rdCmd; !selectN && {rowN, colN, wrN} == 3'b101; endsequence
   sequence wrCmd; !selectN && {rowN, colN, wrN} == 3'b100; endsequence
   sequence quiet; selectN || {rowN, colN, wrN} == 3'b111; endsequence
   rd_data_a: assert property (rdCmd |=> dqDevOe) else $error("no read drive");
   rd_gap_a: assert property (rdCmd |=> quiet [*2]) else $error("command in read gap");
   rd_single_a: assert property (dqDevOe |=> !dqDevOe) else $error("read drive too long");
   wr_drive_a: assert property (wrCmd |-> dqCtlOe) else $error("no write drive");
   bus_excl_a: assert property (!(dqDevOe && dqCtlOe)) else $error("bus contention");
   cke_quiet_a: assert property (!clkEnable |=> !dqDevOe) else $error("drive while stopped");
   cmd_cke_a: assert property ((rdCmd or wrCmd) |-> clkEnable) else $error("access while stopped");
   clk_pair_a: assert property (clockTrue && !clockComplement) else $error("clock pair");
endmodule
`default_nettype wire

// ==== verif/lpddr_pin_command_interface_test.sv ====
// Purpose: Both ends back to back against a model
// Assumes: Read data two cycles after the take edge
// Notes: Memory model is an array of words
`include "lpc_regs.svh"
`default_nettype none
module lpddr_pin_command_interface_test;
   timeunit 1ns;
   timeprecision 1ps;
   import lpc_pkg::*;
   // ****
   // Bench
   // ****
   logic sysClk = 1'b0, rst = 1'b1, reqValid = 1'b0, clkEnableReq = 1'b1, hotJunction = 1'b0;
   lpc_cmd_t reqCmd = 4'h7;
   logic [1:0] reqBank = 2'h0, reqMask = 2'h0, pwrState;
   logic [13:0] reqAddr = 14'h0000, modeReg0;
   logic [15:0] reqData = 16'h0000, rdData, memModel [64];
   logic reqReady, rdValid, hotFlag;
   logic [3:0] bankOpen;
   int fail_count = 0, tests_run = 0;
   initial forever #2 sysClk = ~sysClk;
   lpc_if #(.DW(16)) pins (.sysClk(sysClk));
   lpc_device #(.DW(16), .DEPTH(64)) lpc_device_inst (.sysClk(sysClk), .rst(rst), .pins(pins),
      .hotJunction(hotJunction), .pwrState(pwrState), .bankOpen(bankOpen), .modeReg0(modeReg0));
   lpc_controller #(.DW(16)) lpc_controller_inst (.sysClk(sysClk), .rst(rst), .pins(pins),
      .reqValid(reqValid), .reqReady(reqReady), .reqCmd(reqCmd), .reqBank(reqBank), .reqAddr(reqAddr),
      .reqData(reqData), .reqMask(reqMask), .clkEnableReq(clkEnableReq), .rdValid(rdValid),
      .rdData(rdData), .hotFlag(hotFlag));
   lpc_pins_monitor lpc_pins_monitor_inst (.sysClk(sysClk), .rst(rst), .clockTrue(pins.clockTrue),
      .clockComplement(pins.clockComplement), .clkEnable(pins.clkEnable), .selectN(pins.selectN),
      .rowN(pins.rowN), .colN(pins.colN), .wrN(pins.wrN), .dqCtlOe(pins.dqCtlOe), .dqDevOe(pins.dqDevOe));
   task automatic close_out;
      $display("tests_run %0d fail_count %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic issue(input lpc_cmd_t c, input logic [1:0] b, input logic [13:0] a,
         input logic [15:0] d, input logic [1:0] m);
      int n;
      n = 0;
      @(posedge sysClk);
      {reqValid, reqCmd, reqBank, reqAddr, reqData, reqMask} <= {1'b1, c, b, a, d, m};
      do begin
         @(negedge sysClk);
         n++;
      end while (reqReady !== 1'b1 && n < 50);
      if (reqReady !== 1'b1) begin
         chk(16'h0000, 16'h0001);
         close_out;
      end
      @(posedge sysClk);
      reqValid <= 1'b0;
   endtask
   task automatic await(input int which, input logic [15:0] exp);
      logic [15:0] got;
      int n;
      n = 0;
      do begin
         @(negedge sysClk);
         got = which == 0 ? 16'(pwrState) : which == 1 ? 16'(hotFlag) : which == 2 ? 16'(bankOpen) : 16'(modeReg0);
         n++;
      end while (got !== exp && n < 20);
      chk(got, exp);
      if (got !== exp) begin
         close_out;
      end
   endtask
   task automatic drive(input logic cke, input logic hot);
      @(posedge sysClk);
      clkEnableReq <= cke;
      hotJunction <= hot;
   endtask
   initial begin
      logic [5:0] a;
      logic [15:0] d;
      logic [1:0] m;
      int n;
      void'($urandom(32'h8b4d));
      repeat (5) @(posedge sysClk);
      rst <= 1'b0;
      issue(`LPC_CMD_ACT, 2'h0, 14'h0000, 16'h0000, 2'h0);
      for (int i = 0; i < 6; i++) begin
         a = 6'($urandom);
         d = 16'($urandom);
         m = 2'($urandom);
         issue(`LPC_CMD_WR, 2'h0, {8'h00, a}, d, 2'h0);
         memModel[a] = d;
         d = 16'($urandom);
         issue(`LPC_CMD_WR, 2'h0, {8'h00, a}, d, m);
         for (int j = 0; j < 2; j++) if (!m[j]) memModel[a][8*j+:8] = d[8*j+:8];
         issue(`LPC_CMD_RD, 2'h0, {8'h00, a}, 16'h0000, 2'h0);
         n = 0;
         do begin
            @(negedge sysClk);
            n++;
         end while (rdValid !== 1'b1 && n < 20);
         chk(rdData, memModel[a]);
         chk(16'(n), 16'h0003);
         if (rdValid !== 1'b1) begin
            close_out;
         end
      end
      $display("test data done");
      for (int b = 0; b < 4; b++) issue(`LPC_CMD_ACT, 2'(b), 14'h0000, 16'h0000, 2'h0);
      await(2, 16'h000f);
      issue(`LPC_CMD_WR, 2'h3, 14'h0400, 16'h0000, 2'h3);
      await(2, 16'h0007);
      issue(`LPC_CMD_PRE, 2'h1, 14'h0000, 16'h0000, 2'h0);
      await(2, 16'h0005);
      issue(`LPC_CMD_PRE, 2'h0, 14'h0400, 16'h0000, 2'h0);
      await(2, 16'h0000);
      $display("test bank done");
      d = 16'($urandom);
      issue(`LPC_CMD_MRS, 2'h0, d[13:0], 16'h0000, 2'h0);
      await(3, {2'h0, d[13:0]});
      issue(`LPC_CMD_MRS, 2'h1, ~d[13:0], 16'h0000, 2'h0);
      repeat (3) @(posedge sysClk);
      await(3, {2'h0, d[13:0]});
      $display("test mode done");
      drive(1'b0, 1'b1);
      await(0, 16'h0001);
      await(1, 16'h0001);
      drive(1'b1, 1'b0);
      await(0, 16'h0000);
      await(1, 16'h0000);
      issue(`LPC_CMD_ACT, 2'h2, 14'h0000, 16'h0000, 2'h0);
      drive(1'b0, 1'b0);
      await(0, 16'h0002);
      drive(1'b1, 1'b0);
      await(0, 16'h0000);
      issue(`LPC_CMD_PRE, 2'h0, 14'h0400, 16'h0000, 2'h0);
      await(2, 16'h0000);
      fork
         issue(`LPC_CMD_REF, 2'h0, 14'h0000, 16'h0000, 2'h0);
         drive(1'b0, 1'b0);
      join
      await(0, 16'h0003);
      drive(1'b1, 1'b0);
      await(0, 16'h0000);
      $display("test power done");
      close_out;
   end
endmodule
`default_nettype wire
